// >>> logic/ipd_indexed_decoder.sv
// Indexed postbyte decoder with page-two prefix and address generation
// What this block does
// - One postbyte, then zero to two extensions
// - rr0nnnnn: signed 5-bit offset, no extension
// - 111rr0zs: 9-bit (sign in s) or 16-bit
// - 111rr011 is 16-bit offset indirect
// - rr1pnnnn: pre/post modify by 1..8
// - Auto modify base only X, Y, stack pointer
// - 111rr1aa: unsigned A, B or D offset
// - 111rr111: D offset indexed indirect
// - Prefix 18 selects second opcode page
// - Postbyte and extension bytes carry operand info
// - Address is base plus offset
// - 9-bit takes one byte, 16-bit two
// - Indirect: address holds operand pointer
`default_nettype none
module ipd_indexed_decoder (
    input  wire logic        I_CLOCK,
    input  wire logic        I_RST_N,
    input  wire logic        i_byte_valid,
    input  wire logic [7:0]  i_byte,
    input  wire logic        i_opcode_indexed,
    input  wire logic [15:0] i_reg_x,
    input  wire logic [15:0] i_reg_y,
    input  wire logic [15:0] i_stack_pointer,
    input  wire logic [15:0] i_program_counter,
    input  wire logic [7:0]  i_acc_a,
    input  wire logic [7:0]  i_acc_b,
    output var  logic        O_OPCODE_VALID,
    output var  logic [7:0]  O_OPCODE,
    output var  logic        O_PAGE2,
    output var  logic        O_DONE,
    output var  logic [15:0] O_EFF_ADDR,
    output var  logic        O_INDIRECT,
    output var  logic        O_WB_EN,
    output var  logic [1:0]  O_WB_SEL,
    output var  logic [15:0] O_WB_VALUE,
    output var  logic        O_ILLEGAL,
    output var  logic [3:0]  O_MODE
);
    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    ipd_pkg::ipd_state_t state_q, state_d;
    logic        page2_q;
    logic [7:0]  postbyte_q;
    logic [7:0]  ext_hi_q;
    logic [7:0]  ext_lo_q;

    ipd_pkg::ipd_mode_t mode;
    logic [1:0]  base_register_select;
    logic [1:0]  ext_count;
    logic        illegal;
    logic [15:0] const_offset;

    ipd_postbyte_field u_field (
        .i_postbyte             (postbyte_q),
        .o_mode                 (mode),
        .o_base_register_select (base_register_select),
        .o_ext_count            (ext_count),
        .o_illegal              (illegal),
        .o_const_offset         (const_offset)
    );

    // -----------------------------------------------------------------
    // Byte stream sequencing
    // -----------------------------------------------------------------
    wire logic is_prefix = (i_byte == ipd_pkg::PAGE2_PREFIX);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ipd_pkg::ST_OPCODE: begin
                if (i_byte_valid && !is_prefix && i_opcode_indexed) begin
                    state_d = ipd_pkg::ST_POSTBYTE;
                end
            end
            ipd_pkg::ST_POSTBYTE: begin
                if (i_byte_valid) begin
                    state_d = ipd_pkg::ST_RESOLVE;
                end
            end
            ipd_pkg::ST_RESOLVE: begin
                // Postbyte fields are registered now, so extension count is known
                if (ext_count == 2'h2) begin
                    state_d = ipd_pkg::ST_EXT_HI;
                end else if (ext_count == 2'h1) begin
                    state_d = ipd_pkg::ST_EXT_LO;
                end else begin
                    state_d = ipd_pkg::ST_OPCODE;
                end
            end
            ipd_pkg::ST_EXT_HI: begin
                if (i_byte_valid) begin
                    state_d = ipd_pkg::ST_EXT_LO;
                end
            end
            ipd_pkg::ST_EXT_LO: begin
                if (i_byte_valid) begin
                    state_d = ipd_pkg::ST_OPCODE;
                end
            end
            default: state_d = ipd_pkg::ST_OPCODE;
        endcase
    end

    wire logic take_opcode = (state_q == ipd_pkg::ST_OPCODE) && i_byte_valid;
    wire logic finish_now  = ((state_q == ipd_pkg::ST_RESOLVE) && (ext_count == 2'h0))
                          || ((state_q == ipd_pkg::ST_EXT_LO) && i_byte_valid);

    // -----------------------------------------------------------------
    // Offset and address generation
    // -----------------------------------------------------------------
    wire logic [15:0] base_value =
        (base_register_select == ipd_pkg::REG_X)  ? i_reg_x :
        (base_register_select == ipd_pkg::REG_Y)  ? i_reg_y :
        (base_register_select == ipd_pkg::REG_STACK) ? i_stack_pointer :
                                                    i_program_counter;
    wire logic [15:0] acc_d = {i_acc_a, i_acc_b};
    // Low extension byte is the live byte in the final cycle
    wire logic [7:0]  ext_lo_now = (state_q == ipd_pkg::ST_EXT_LO) ? i_byte : ext_lo_q;
    wire logic [15:0] offset =
        (mode == ipd_pkg::MODE_OFS9)  ? {const_offset[15:8], ext_lo_now} :
        (mode == ipd_pkg::MODE_OFS16 || mode == ipd_pkg::MODE_OFS16_IND)
                                      ? {ext_hi_q, ext_lo_now} :
        (mode == ipd_pkg::MODE_ACC_A) ? {8'h00, i_acc_a} :
        (mode == ipd_pkg::MODE_ACC_B) ? {8'h00, i_acc_b} :
        (mode == ipd_pkg::MODE_ACC_D || mode == ipd_pkg::MODE_ACC_D_IND)
                                      ? acc_d :
        (mode == ipd_pkg::MODE_POST_MOD) ? ipd_pkg::ZERO16 :
                                        const_offset;
    wire logic [15:0] sum_addr   = base_value + offset;
    wire logic [15:0] modified   = base_value + const_offset;
    // Post form addresses with the old value, pre form with the new one
    wire logic [15:0] eff_addr   = sum_addr;
    wire logic        is_auto    = (mode == ipd_pkg::MODE_PRE_MOD)
                                || (mode == ipd_pkg::MODE_POST_MOD);
    wire logic        is_indir   = (mode == ipd_pkg::MODE_OFS16_IND)
                                || (mode == ipd_pkg::MODE_ACC_D_IND);

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_q <= ipd_pkg::ST_OPCODE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            page2_q        <= 1'b0;
            O_OPCODE_VALID <= 1'b0;
            O_OPCODE       <= 8'h00;
            O_PAGE2        <= 1'b0;
        end else begin
            O_OPCODE_VALID <= take_opcode && !is_prefix;
            if (take_opcode && is_prefix) begin
                page2_q <= 1'b1;
            end else if (take_opcode) begin
                page2_q  <= 1'b0;
                O_PAGE2  <= page2_q;
                O_OPCODE <= i_byte;
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            postbyte_q <= 8'h00;
            ext_hi_q   <= 8'h00;
            ext_lo_q   <= 8'h00;
        end else begin
            if (state_q == ipd_pkg::ST_POSTBYTE && i_byte_valid) begin
                postbyte_q <= i_byte;
                ext_lo_q   <= 8'h00;
            end
            if (state_q == ipd_pkg::ST_EXT_HI && i_byte_valid) begin
                ext_hi_q <= i_byte;
            end
            if (state_q == ipd_pkg::ST_EXT_LO && i_byte_valid) begin
                ext_lo_q <= i_byte;
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_DONE     <= 1'b0;
            O_EFF_ADDR <= 16'h0000;
            O_INDIRECT <= 1'b0;
            O_WB_EN    <= 1'b0;
            O_WB_SEL   <= 2'h0;
            O_WB_VALUE <= 16'h0000;
            O_ILLEGAL  <= 1'b0;
            O_MODE     <= 4'h0;
        end else begin
            O_DONE  <= finish_now;
            O_WB_EN <= finish_now && is_auto && !illegal;
            if (finish_now) begin
                O_EFF_ADDR <= eff_addr;
                O_INDIRECT <= is_indir;
                O_WB_SEL   <= base_register_select;
                O_WB_VALUE <= modified;
                O_ILLEGAL  <= illegal;
                O_MODE     <= mode;
            end
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    sequence s_short_postbyte;
        state_q == ipd_pkg::ST_POSTBYTE && i_byte_valid
        && i_byte[7:5] != ipd_pkg::LONG_TAG;
    endsequence

    property p_short_done;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        s_short_postbyte |-> ##2 O_DONE;
    endproperty
    a_short_done: assert property (p_short_done) else $error("short form not done");

    property p_ofs5_addr;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (finish_now && mode == ipd_pkg::MODE_OFS5)
            |=> O_EFF_ADDR == $past(base_value) + {{11{$past(postbyte_q[4])}},
                                                   $past(postbyte_q[4:0])};
    endproperty
    a_ofs5_addr: assert property (p_ofs5_addr) else $error("5-bit offset wrong");

    property p_ofs16_two_ext;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (state_q == ipd_pkg::ST_RESOLVE && postbyte_q[7:5] == ipd_pkg::LONG_TAG
         && !postbyte_q[2] && postbyte_q[1]) |=> state_q == ipd_pkg::ST_EXT_HI;
    endproperty
    a_ofs16_two_ext: assert property (p_ofs16_two_ext) else $error("16-bit ext count");

    property p_ind_flag;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        finish_now |=> O_INDIRECT == ($past(postbyte_q[7:5]) == ipd_pkg::LONG_TAG
                                      && $past(postbyte_q[1:0]) == 2'h3);
    endproperty
    a_ind_flag: assert property (p_ind_flag) else $error("indirect flag wrong");

    property p_pc_auto_illegal;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (finish_now && is_auto)
            |=> O_WB_EN && !O_ILLEGAL && O_WB_SEL != ipd_pkg::REG_PROG;
    endproperty
    a_pc_auto_illegal: assert property (p_pc_auto_illegal) else $error("program counter auto");

    property p_post_old;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (finish_now && mode == ipd_pkg::MODE_POST_MOD) |=> O_EFF_ADDR == $past(base_value);
    endproperty
    a_post_old: assert property (p_post_old) else $error("post modify address");

    property p_prefix_page2;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (take_opcode && is_prefix) ##1 (take_opcode && !is_prefix) |=> O_PAGE2;
    endproperty
    a_prefix_page2: assert property (p_prefix_page2) else $error("page two lost");

    property p_acc_b;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (finish_now && mode == ipd_pkg::MODE_ACC_B)
            |=> O_EFF_ADDR == $past(base_value) + {8'h00, $past(i_acc_b)};
    endproperty
    a_acc_b: assert property (p_acc_b) else $error("B offset wrong");
endmodule : ipd_indexed_decoder
`default_nettype wire

// >>> logic/ipd_pkg.sv
// Package for the indexed postbyte decoder: encodings, modes and states
`default_nettype none
package ipd_pkg;
    // -----------------------------------------------------------------
    // Byte values and field positions
    // -----------------------------------------------------------------
    localparam logic [7:0] PAGE2_PREFIX    = 8'h18;
    localparam int         SEL_MSB         = 7;
    localparam int         SEL_LSB         = 6;
    localparam int         SEL_ALT_MSB     = 4;
    localparam int         SEL_ALT_LSB     = 3;
    localparam int         CLASS_BIT       = 5;
    localparam int         AUTO_P_BIT      = 4;
    localparam logic [2:0] LONG_TAG        = 3'h7;
    localparam logic [1:0] ACC_A           = 2'h0;
    localparam logic [1:0] ACC_B           = 2'h1;
    localparam logic [1:0] ACC_D           = 2'h2;
    localparam logic [1:0] ACC_D_IND       = 2'h3;
    localparam logic [1:0] REG_X           = 2'h0;
    localparam logic [1:0] REG_Y           = 2'h1;
    localparam logic [1:0] REG_STACK       = 2'h2;
    localparam logic [1:0] REG_PROG        = 2'h3;
    localparam logic [15:0] ZERO16         = 16'h0000;
    localparam logic [15:0] ONES16         = 16'hffff;

    // -----------------------------------------------------------------
    // Addressing modes and fetch states
    // -----------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_OFS5,
        MODE_OFS9,
        MODE_OFS16,
        MODE_OFS16_IND,
        MODE_PRE_MOD,
        MODE_POST_MOD,
        MODE_ACC_A,
        MODE_ACC_B,
        MODE_ACC_D,
        MODE_ACC_D_IND
    } ipd_mode_t;

    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_POSTBYTE,
        ST_EXT_HI,
        ST_EXT_LO,
        ST_RESOLVE
    } ipd_state_t;
endpackage : ipd_pkg
`default_nettype wire

// >>> logic/ipd_postbyte_field.sv
// Combinational field decoder for one indexed postbyte
`default_nettype none
module ipd_postbyte_field (
    input  wire logic [7:0]  i_postbyte,
    output var  ipd_pkg::ipd_mode_t o_mode,
    output var  logic [1:0]  o_base_register_select,
    output var  logic [1:0]  o_ext_count,
    output var  logic        o_illegal,
    output var  logic [15:0] o_const_offset
);
    // -----------------------------------------------------------------
    // Field extraction
    // -----------------------------------------------------------------
    wire logic       long_form = (i_postbyte[7:5] == ipd_pkg::LONG_TAG);
    wire logic       acc_form  = i_postbyte[2];
    wire logic [1:0] acc_sel   = i_postbyte[1:0];
    wire logic [1:0] sel_short = i_postbyte[ipd_pkg::SEL_MSB:ipd_pkg::SEL_LSB];
    wire logic [1:0] sel_long  = i_postbyte[ipd_pkg::SEL_ALT_MSB:ipd_pkg::SEL_ALT_LSB];
    // Long tag wins, so a program counter base can never reach auto modify
    wire logic       auto_form = !long_form && i_postbyte[ipd_pkg::CLASS_BIT];
    // Step: n 0..7 means +1..+8, 8..15 means -8..-1
    wire logic [3:0] step_n    = i_postbyte[3:0];
    wire logic [15:0] step_val = step_n[3] ? {{12{1'b1}}, step_n}
                                           : {12'h000, step_n + 4'h1};

    always_comb begin
        o_base_register_select = long_form ? sel_long : sel_short;
        o_ext_count    = 2'h0;
        o_illegal      = 1'b0;
        o_const_offset = ipd_pkg::ZERO16;
        o_mode         = ipd_pkg::MODE_OFS5;
        if (!long_form && !i_postbyte[ipd_pkg::CLASS_BIT]) begin
            o_mode         = ipd_pkg::MODE_OFS5;
            o_const_offset = {{11{i_postbyte[4]}}, i_postbyte[4:0]};
        end else if (auto_form) begin
            o_mode = i_postbyte[ipd_pkg::AUTO_P_BIT] ? ipd_pkg::MODE_POST_MOD
                                                     : ipd_pkg::MODE_PRE_MOD;
            o_const_offset = step_val;
            o_illegal      = (sel_short == ipd_pkg::REG_PROG);
        end else if (!acc_form) begin
            if (i_postbyte[1:0] == 2'h3) begin
                o_mode      = ipd_pkg::MODE_OFS16_IND;
                o_ext_count = 2'h2;
            end else if (i_postbyte[1]) begin
                o_mode      = ipd_pkg::MODE_OFS16;
                o_ext_count = 2'h2;
            end else begin
                o_mode         = ipd_pkg::MODE_OFS9;
                o_ext_count    = 2'h1;
                o_const_offset = {{8{i_postbyte[0]}}, 8'h00};
            end
        end else begin
            case (acc_sel)
                ipd_pkg::ACC_A:     o_mode = ipd_pkg::MODE_ACC_A;
                ipd_pkg::ACC_B:     o_mode = ipd_pkg::MODE_ACC_B;
                ipd_pkg::ACC_D:     o_mode = ipd_pkg::MODE_ACC_D;
                default:            o_mode = ipd_pkg::MODE_ACC_D_IND;
            endcase
        end
    end
endmodule : ipd_postbyte_field
`default_nettype wire

// >>> bench/test_indexed_postbyte_decoder.sv
// Self-checking testbench for the indexed postbyte decoder
`default_nettype none
module test_indexed_postbyte_decoder;
    timeunit 1ns;
    timeprecision 100ps;

    // ---------------------------------------------------------------
    // Stimulus and observation signals
    // ---------------------------------------------------------------
    logic        clk       = 1'b0;
    logic        rst_n     = 1'b0;
    logic        byte_vld  = 1'b0;
    logic [7:0]  byte_in   = 8'h00;
    logic        opc_idx   = 1'b0;
    logic [15:0] reg_x     = 16'h1000;
    logic [15:0] reg_y     = 16'h2200;
    logic [15:0] reg_stk   = 16'h3330;
    logic [15:0] reg_prog  = 16'h4444;
    logic [7:0]  acc_a     = 8'h81;
    logic [7:0]  acc_b     = 8'hf3;
    logic        opc_vld;
    logic [7:0]  opcode;
    logic        page2;
    logic        done;
    logic [15:0] eff_addr;
    logic        indirect;
    logic        wb_en;
    logic [1:0]  wb_sel;
    logic [15:0] wb_value;
    logic        illegal;
    logic [3:0]  mode;
    int          err_total = 0;
    int          cmp_count = 0;

    ipd_indexed_decoder dut (
        .I_CLOCK           (clk),
        .I_RST_N           (rst_n),
        .i_byte_valid      (byte_vld),
        .i_byte            (byte_in),
        .i_opcode_indexed  (opc_idx),
        .i_reg_x           (reg_x),
        .i_reg_y           (reg_y),
        .i_stack_pointer   (reg_stk),
        .i_program_counter (reg_prog),
        .i_acc_a           (acc_a),
        .i_acc_b           (acc_b),
        .O_OPCODE_VALID    (opc_vld),
        .O_OPCODE          (opcode),
        .O_PAGE2           (page2),
        .O_DONE            (done),
        .O_EFF_ADDR        (eff_addr),
        .O_INDIRECT        (indirect),
        .O_WB_EN           (wb_en),
        .O_WB_SEL          (wb_sel),
        .O_WB_VALUE        (wb_value),
        .O_ILLEGAL         (illegal),
        .O_MODE            (mode)
    );

    always #20 clk = ~clk;

    // ---------------------------------------------------------------
    // Shared helpers
    // ---------------------------------------------------------------
    task automatic close_out();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One byte, taken at the next edge; strobe stays up for the next byte
    task automatic put(input logic [7:0] b, input logic ix);
        byte_in  = b;
        opc_idx  = ix;
        byte_vld = 1'b1;
        @(posedge clk);
        #1;
    endtask : put

    function automatic logic [15:0] base_of(input logic [1:0] sel);
        case (sel)
            2'h0:    return reg_x;
            2'h1:    return reg_y;
            2'h2:    return reg_stk;
            default: return reg_prog;
        endcase
    endfunction : base_of

    // Stray byte in the resolve slot must be dropped, not counted as extension
    task automatic decode(input logic [7:0] pb, input int n_ext, input logic [15:0] ext);
        put(8'ha6, 1'b1);
        chk(opc_vld, 1'b1);
        chk(opcode, 8'ha6);
        put(pb, 1'b0);
        put(8'h5a, 1'b0);
        if (n_ext == 2) put(ext[15:8], 1'b0);
        if (n_ext >= 1) put(ext[7:0], 1'b0);
        chk(done, 1'b1);
    endtask : decode

    task automatic expect_out(input logic [3:0] md, input logic [15:0] addr, input logic ind,
                              input logic wbe, input logic [1:0] sel, input logic [15:0] wbv);
        chk(mode, md);
        chk(eff_addr, addr);
        chk(indirect, ind);
        chk(wb_en, wbe);
        chk(illegal, 1'b0);
        if (wbe) begin
            chk(wb_sel, sel);
            chk(wb_value, wbv);
        end
    endtask : expect_out

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_ofs5();
        for (int r = 0; r < 4; r++) begin
            decode({r[1:0], 1'b0, 5'h10}, 0, 16'h0000);
            expect_out(ipd_pkg::MODE_OFS5, base_of(r[1:0]) - 16'h0010, 1'b0, 1'b0, 2'h0, 16'h0);
            decode({r[1:0], 1'b0, 5'h0f}, 0, 16'h0000);
            expect_out(ipd_pkg::MODE_OFS5, base_of(r[1:0]) + 16'h000f, 1'b0, 1'b0, 2'h0, 16'h0);
        end
    endtask : t_ofs5

    task automatic t_const_long();
        for (int r = 0; r < 4; r++) begin
            decode({3'h7, r[1:0], 3'h1}, 1, 16'h0000);
            expect_out(ipd_pkg::MODE_OFS9, base_of(r[1:0]) - 16'h0100, 1'b0, 1'b0, 2'h0, 16'h0);
            decode({3'h7, r[1:0], 3'h0}, 1, 16'h00ff);
            expect_out(ipd_pkg::MODE_OFS9, base_of(r[1:0]) + 16'h00ff, 1'b0, 1'b0, 2'h0, 16'h0);
            decode({3'h7, r[1:0], 3'h2}, 2, 16'h8001);
            expect_out(ipd_pkg::MODE_OFS16, base_of(r[1:0]) + 16'h8001, 1'b0, 1'b0, 2'h0, 16'h0);
            decode({3'h7, r[1:0], 3'h3}, 2, 16'h1234);
            expect_out(ipd_pkg::MODE_OFS16_IND, base_of(r[1:0]) + 16'h1234, 1'b1, 1'b0, 2'h0, 16'h0);
        end
    endtask : t_const_long

    // Step extremes both ways, pre and post, on every legal base
    task automatic t_auto();
        logic [3:0]  nv [4] = '{4'h0, 4'h7, 4'h8, 4'hf};
        logic [15:0] nw;
        for (int r = 0; r < 3; r++) begin
            for (int p = 0; p < 2; p++) begin
                for (int k = 0; k < 4; k++) begin
                    nw = (nv[k] < 4'h8) ? base_of(r[1:0]) + {12'h000, nv[k]} + 16'h0001
                                        : base_of(r[1:0]) + {12'hfff, nv[k]};
                    decode({r[1:0], 1'b1, p[0], nv[k]}, 0, 16'h0000);
                    if (p == 0) expect_out(ipd_pkg::MODE_PRE_MOD, nw, 1'b0, 1'b1, r[1:0], nw);
                    else expect_out(ipd_pkg::MODE_POST_MOD, base_of(r[1:0]), 1'b0, 1'b1, r[1:0], nw);
                end
            end
        end
    endtask : t_auto

    // Auto pattern with field 11 falls into the long constant space
    task automatic t_auto_pc();
        for (int p = 0; p < 2; p++) begin
            decode({2'h3, 1'b1, p[0], 4'h2}, 2, 16'h0040);
            chk(illegal, 1'b0);
            chk(wb_en, 1'b0);
            chk(mode, ipd_pkg::MODE_OFS16);
            chk(eff_addr, base_of({p[0], 1'b0}) + 16'h0040);
        end
    endtask : t_auto_pc

    // A holds a high bit set, so a sign-extended offset would show
    task automatic t_acc();
        for (int r = 0; r < 4; r++) begin
            decode({3'h7, r[1:0], 3'h4}, 0, 16'h0000);
            expect_out(ipd_pkg::MODE_ACC_A, base_of(r[1:0]) + {8'h00, acc_a}, 1'b0, 1'b0, 2'h0, 16'h0);
            decode({3'h7, r[1:0], 3'h5}, 0, 16'h0000);
            expect_out(ipd_pkg::MODE_ACC_B, base_of(r[1:0]) + {8'h00, acc_b}, 1'b0, 1'b0, 2'h0, 16'h0);
            decode({3'h7, r[1:0], 3'h6}, 0, 16'h0000);
            expect_out(ipd_pkg::MODE_ACC_D, base_of(r[1:0]) + {acc_a, acc_b}, 1'b0, 1'b0, 2'h0, 16'h0);
            decode({3'h7, r[1:0], 3'h7}, 0, 16'h0000);
            expect_out(ipd_pkg::MODE_ACC_D_IND, base_of(r[1:0]) + {acc_a, acc_b}, 1'b1, 1'b0, 2'h0, 16'h0);
        end
    endtask : t_acc

    task automatic t_page();
        put(8'h18, 1'b0);
        chk(opc_vld, 1'b0);
        put(8'h18, 1'b0);
        put(8'h3c, 1'b0);
        chk(opc_vld, 1'b1);
        chk(page2, 1'b1);
        chk(opcode, 8'h3c);
        put(8'h3d, 1'b0);
        chk(page2, 1'b0);
    endtask : t_page

    // ---------------------------------------------------------------
    // Main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        #1;
        chk(done, 1'b0);
        chk(opc_vld, 1'b0);
        rst_n = 1'b1;
        t_ofs5();
        t_const_long();
        t_auto();
        t_auto_pc();
        t_acc();
        t_page();
        close_out();
    end

    initial begin
        #(40 * 5000);
        err_total++;
        close_out();
    end
endmodule : test_indexed_postbyte_decoder
`default_nettype wire
